// [shared/packer_params.svh]
`ifndef PACKER_PARAMS_SVH
`define PACKER_PARAMS_SVH

// register byte offsets
`define CTRL_OFFSET     12'h000
`define STAT_OFFSET     12'h004
// control fields
`define CTRL_RUN_BIT    0
`define CTRL_CPLX_BIT   1
`define CTRL_RES24_BIT  2
`define CTRL_PORT_LSB   4
`define CTRL_PORT_MSB   5
`define CTRL_RESET      32'h0000_0000
// status fields
`define STAT_RUN_BIT    0
`define STAT_HAVE_BIT   1
`define STAT_PAIR_BIT   2
`define STAT_FMT_LSB    4
`define STAT_FMT_MSB    7
`define STAT_CRED_LSB   8
`define STAT_CRED_MSB   15
`define STAT_CNT_LSB    16
`define STAT_CNT_MSB    31
// memory rate budget in half-bytes: 1.5 bytes per clock is 3 half-bytes
`define CREDIT_GAIN     8'h03
`define CREDIT_CAP      16
`define COST_REG_READ   8'h04
`define COST_BYTE       8'h02
`define COST_FIBER      8'h08

`endif

// [shared/packer_pkg.sv]
package packer_pkg;

  typedef enum logic [1:0] {
    PORT_REG_READ,
    PORT_BYTE_SERIAL,
    PORT_FIBER
  } port_sel_type;

  typedef struct packed {
    port_sel_type port;
    logic         cplx;
    logic         res24;
  } fmt_type;

  typedef struct packed {
    logic [23:0] re;
    logic [23:0] im;
  } sample_type;

  typedef struct packed {
    logic [31:0]  data;
    port_sel_type port;
  } xfer_type;

  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } run_state_type;

endpackage

// [src/sample_output_packer.sv]
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "packer_params.svh"
// How it works
// - real 12-bit register port: sample over four zeros
// - complex 12-bit register port: real word, then imaginary
// - real 24-bit register port: bits 23:8, then 7:0 padded
// - complex 24-bit register port: four words, real first
// - 12-bit byte port: bits 11:4, then 3:0 padded
// - 24-bit byte port: three bytes then zero byte
// - real 12-bit fiber: two samples, earlier one upper
// - complex 12-bit fiber: padded real over padded imaginary
// - 24-bit fiber: one word per component, zeros below
// - split components go most significant part first
// - memory write rate capped at 1.5 bytes/clock
// - sample rate follows from byte rate budget
// - output port defaults to register read after reset
// - resolution selects 12 or 24 bit packing
module sample_output_packer
  import packer_pkg::*;
#(
  parameter int CREDIT_CAP = `CREDIT_CAP
)(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        smp_valid,
  input  wire sample_type  smp,
  output logic             smp_ready,
  output logic             out_valid,
  output xfer_type         out_xfer,
  input  wire logic        out_ready
);

  // the cap leaves room for one gain step, so the 8-bit credit sum never wraps
  if (CREDIT_CAP < 8 || CREDIT_CAP > 252)
  begin : g_cap_check
    $error("CREDIT_CAP must hold one fiber word and fit 8 bits");
  end

  localparam logic [7:0] CAP = 8'(CREDIT_CAP);

  function automatic logic [3:0] comp_steps(fmt_type f);
    case (f.port)
      PORT_REG_READ:    comp_steps = f.res24 ? 4'h2 : 4'h1;
      PORT_BYTE_SERIAL: comp_steps = f.res24 ? 4'h4 : 4'h2;
      default:          comp_steps = 4'h1;
    endcase
  endfunction

  function automatic logic [3:0] total_steps(fmt_type f);
    if (f.port == PORT_FIBER && !f.res24)
      total_steps = 4'h1;
    else
      total_steps = f.cplx ? comp_steps(f) << 1 : comp_steps(f);
  endfunction

  function automatic logic [7:0] xfer_cost(port_sel_type p);
    case (p)
      PORT_REG_READ:    xfer_cost = `COST_REG_READ;
      PORT_BYTE_SERIAL: xfer_cost = `COST_BYTE;
      default:          xfer_cost = `COST_FIBER;
    endcase
  endfunction

  // one transfer for a given step; the fiber real 12-bit pair is merged by the caller
  function automatic logic [31:0] pack_word(fmt_type f, logic [3:0] step, sample_type s);
    logic [3:0]  cps;
    logic [3:0]  idx;
    logic [23:0] c;
    cps = comp_steps(f);
    idx = step;
    c   = s.re;
    if (f.cplx && step >= cps)
    begin
      c   = s.im;
      idx = step - cps;
    end
    pack_word = 32'h0000_0000;
    case (f.port)
      PORT_REG_READ:
        if (!f.res24)
          pack_word[15:0] = {c[11:0], 4'h0};
        else if (idx == 4'h0)
          pack_word[15:0] = c[23:8];
        else
          pack_word[15:0] = {c[7:0], 8'h00};
      PORT_BYTE_SERIAL:
        if (!f.res24)
          pack_word[7:0] = (idx == 4'h0) ? c[11:4] : {c[3:0], 4'h0};
        else
          case (idx[1:0])
            2'h0:    pack_word[7:0] = c[23:16];
            2'h1:    pack_word[7:0] = c[15:8];
            2'h2:    pack_word[7:0] = c[7:0];
            default: pack_word[7:0] = 8'h00;
          endcase
      default:
        if (f.res24)
          pack_word = {c, 8'h00};
        else
          pack_word = {s.re[11:0], 4'h0, s.im[11:0], 4'h0};
    endcase
  endfunction

  logic [31:0]   ctrl_q;
  fmt_type       fmt_q;
  run_state_type state_q;
  sample_type    smp_q;
  logic          have_q;
  logic [15:0]   pair_q;
  logic          pair_have_q;
  logic [3:0]    step_q;
  logic [7:0]    credit_q;
  logic [15:0]   count_q;
  logic          spare_v_q;
  xfer_type      spare_q;

  logic          run_req;
  logic          pair_first;
  logic          fire;
  logic          emit;
  logic          last_step;
  logic          done;
  logic [7:0]    cost;
  logic [31:0]   word_w;
  logic          have_d;
  logic          apb_done;
  logic          addr_ok;
  logic [31:0]   stat_w;

  assign run_req    = ctrl_q[`CTRL_RUN_BIT];
  assign cost       = xfer_cost(fmt_q.port);
  assign pair_first = fmt_q.port == PORT_FIBER && !fmt_q.res24 && !fmt_q.cplx && !pair_have_q;
  assign last_step  = step_q == total_steps(fmt_q) - 4'h1;
  // back-pressure from the two-entry buffer stalls packing, so no word is dropped
  assign fire       = state_q == ST_RUN && have_q && !spare_v_q
                      && (pair_first || credit_q >= cost);
  assign emit       = fire && !pair_first;
  assign done       = fire && (pair_first || last_step);

  always_comb
  begin
    if (fmt_q.port == PORT_FIBER && !fmt_q.res24 && !fmt_q.cplx)
      word_w = {pair_q, smp_q.re[11:0], 4'h0};
    else
      word_w = pack_word(fmt_q, step_q, smp_q);
  end

  // apb: one wait state, pready and data registered
  assign apb_done = psel && penable && pready;
  assign addr_ok  = paddr == `CTRL_OFFSET || paddr == `STAT_OFFSET;

  always_comb
  begin
    stat_w = 32'h0000_0000;
    stat_w[`STAT_RUN_BIT]                 = state_q == ST_RUN;
    stat_w[`STAT_HAVE_BIT]                = have_q;
    stat_w[`STAT_PAIR_BIT]                = pair_have_q;
    stat_w[`STAT_FMT_MSB:`STAT_FMT_LSB]   = fmt_q;
    stat_w[`STAT_CRED_MSB:`STAT_CRED_LSB] = credit_q;
    stat_w[`STAT_CNT_MSB:`STAT_CNT_LSB]   = count_q;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      if (psel && penable && !pready && !pwrite)
        prdata <= (paddr == `CTRL_OFFSET) ? ctrl_q
                : (paddr == `STAT_OFFSET) ? stat_w : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      ctrl_q <= `CTRL_RESET;
    else if (apb_done && pwrite && paddr == `CTRL_OFFSET)
      ctrl_q <= {26'h000_0000, pwdata[`CTRL_PORT_MSB:`CTRL_PORT_LSB], 1'b0,
                 pwdata[`CTRL_RES24_BIT:`CTRL_RUN_BIT]};
  end

  // format only follows the control register at start; writes mid-run wait
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_q <= ST_IDLE;
      fmt_q   <= '0;
    end
    else
      case (state_q)
        ST_IDLE:
          if (run_req)
          begin
            state_q <= ST_RUN;
            fmt_q   <= {port_sel_type'(ctrl_q[`CTRL_PORT_MSB:`CTRL_PORT_LSB]),
                        ctrl_q[`CTRL_CPLX_BIT], ctrl_q[`CTRL_RES24_BIT]};
          end
        ST_RUN:
          if (!run_req)
            state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
  end

  always_comb
  begin
    have_d = have_q;
    if (done)
      have_d = 1'b0;
    if (smp_valid && smp_ready)
      have_d = 1'b1;
    if (state_q != ST_RUN || !run_req)
      have_d = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      have_q    <= 1'b0;
      smp_ready <= 1'b0;
      smp_q     <= '0;
    end
    else
    begin
      have_q    <= have_d;
      smp_ready <= state_q == ST_RUN && run_req && !have_d;
      if (smp_valid && smp_ready)
        smp_q <= smp;
    end
  end

  // a stopped measurement drops any partial sample and starts clean
  always_ff @(posedge clk)
  begin
    if (!rstn || state_q != ST_RUN)
    begin
      step_q      <= 4'h0;
      pair_have_q <= 1'b0;
      pair_q      <= 16'h0000;
    end
    else if (fire && pair_first)
    begin
      pair_q      <= {smp_q.re[11:0], 4'h0};
      pair_have_q <= 1'b1;
    end
    else if (emit)
    begin
      pair_have_q <= 1'b0;
      step_q      <= last_step ? 4'h0 : step_q + 4'h1;
    end
  end

  // the budget grows with the clock and saturates, so bursts stay bounded
  always_ff @(posedge clk)
  begin
    if (!rstn)
      credit_q <= 8'h00;
    else if (emit)
      credit_q <= (credit_q - cost + `CREDIT_GAIN > CAP) ? CAP
                : credit_q - cost + `CREDIT_GAIN;
    else
      credit_q <= (credit_q + `CREDIT_GAIN > CAP) ? CAP : credit_q + `CREDIT_GAIN;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn || (state_q == ST_IDLE && run_req))
      count_q <= 16'h0000;
    else if (emit)
      count_q <= count_q + 16'h0001;
  end

  // two-entry buffer: output register plus spare
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      out_valid <= 1'b0;
      out_xfer  <= '0;
      spare_v_q <= 1'b0;
      spare_q   <= '0;
    end
    else if (!out_valid || out_ready)
    begin
      out_valid <= spare_v_q || emit;
      out_xfer  <= spare_v_q ? spare_q : xfer_type'{data: word_w, port: fmt_q.port};
      spare_v_q <= 1'b0;
    end
    else if (emit)
    begin
      spare_v_q <= 1'b1;
      spare_q   <= '{data: word_w, port: fmt_q.port};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_run_entered;
    state_q == ST_IDLE ##1 state_q == ST_RUN;
  endsequence
  sequence s_running_on;
    state_q == ST_RUN ##1 state_q == ST_RUN;
  endsequence
  property p_vme12_pad;
    emit && fmt_q.port == PORT_REG_READ && !fmt_q.res24
      |-> word_w[3:0] == 4'h0 && word_w[31:16] == 16'h0000;
  endproperty
  a_vme12_pad: assert property (p_vme12_pad) else $error("12-bit register word pad bad");
  property p_vme12_imag;
    emit && fmt_q.port == PORT_REG_READ && !fmt_q.res24 && fmt_q.cplx && step_q == 4'h1
      |-> word_w[15:4] == smp_q.im[11:0];
  endproperty
  a_vme12_imag: assert property (p_vme12_imag) else $error("imaginary word misplaced");
  property p_vme24_split;
    emit && fmt_q.port == PORT_REG_READ && fmt_q.res24 && step_q == 4'h0
      |-> word_w[15:0] == smp_q.re[23:8];
  endproperty
  a_vme24_split: assert property (p_vme24_split) else $error("24-bit high word bad");
  property p_vme24_order;
    emit && fmt_q.port == PORT_REG_READ && fmt_q.res24 && fmt_q.cplx && step_q == 4'h3
      |-> word_w[15:0] == {smp_q.im[7:0], 8'h00};
  endproperty
  a_vme24_order: assert property (p_vme24_order) else $error("24-bit complex order bad");
  property p_byte12;
    emit && fmt_q.port == PORT_BYTE_SERIAL && !fmt_q.res24 && step_q[0]
      |-> word_w[3:0] == 4'h0;
  endproperty
  a_byte12: assert property (p_byte12) else $error("12-bit low byte pad bad");
  property p_byte24;
    emit && fmt_q.port == PORT_BYTE_SERIAL && fmt_q.res24 && step_q[1:0] == 2'h3
      |-> word_w == 32'h0000_0000;
  endproperty
  a_byte24: assert property (p_byte24) else $error("24-bit zero byte missing");
  property p_fiber;
    emit && fmt_q.port == PORT_FIBER
      |-> word_w[3:0] == 4'h0 && (fmt_q.res24 ? word_w[7:0] == 8'h00 : word_w[19:16] == 4'h0);
  endproperty
  a_fiber: assert property (p_fiber) else $error("fiber word pad bad");
  // the spent cost must really leave the budget, not only be checked against it
  property p_rate;
    emit |-> credit_q >= cost
      ##1 (credit_q <= CAP && credit_q <= $past(credit_q) - $past(cost) + `CREDIT_GAIN);
  endproperty
  a_rate: assert property (p_rate) else $error("memory byte budget overrun");
  property p_fmt_hold;
    s_running_on |-> $stable(fmt_q);
  endproperty
  a_fmt_hold: assert property (p_fmt_hold) else $error("format changed mid-run");
  property p_restart;
    s_run_entered |-> step_q == 4'h0 && !have_q && !pair_have_q;
  endproperty
  a_restart: assert property (p_restart) else $error("run began mid-sample");
  property p_port_default;
    $rose(rstn) |-> ctrl_q[`CTRL_PORT_MSB:`CTRL_PORT_LSB] == 2'h0;
  endproperty
  a_port_default: assert property (p_port_default) else $error("port not reset");

endmodule // sample_output_packer

// [tb/sample_output_packer_test.sv]
`timescale 1ns/1ps
module sample_output_packer_test;
  import packer_pkg::*;
  localparam int CAP = 8;
  logic        clk       = 1'b0;
  logic        rstn      = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [31:0] pwdata    = 32'h0000_0000;
  logic        smp_valid = 1'b0;
  sample_type  smp       = '0;
  logic        hold      = 1'b0;
  logic        stall     = 1'b0;
  logic        rate_clr  = 1'b0;
  logic [15:0] lfsr_q    = 16'h7788;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        smp_ready;
  logic        out_valid;
  xfer_type    out_xfer;
  logic        out_ready;
  xfer_type    exp_q[$];
  logic [31:0] rd;
  logic        err;
  logic [15:0] st;
  int          mismatches = 0;
  int          checked    = 0;
  int          cyc        = 0;
  int          spend      = 0;
  int          cost;

  always #4 clk = ~clk;

  sample_output_packer #(.CREDIT_CAP(CAP)) sample_output_packer_i (
    .clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .smp_valid(smp_valid), .smp(smp), .smp_ready(smp_ready),
    .out_valid(out_valid), .out_xfer(out_xfer), .out_ready(out_ready)
  );
  xfer_sink xfer_sink_i (
    .clk(clk), .rstn(rstn), .hold(hold), .stall(stall), .out_ready(out_ready)
  );

  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(string what, logic [33:0] seen, logic [33:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("pready", {33'b0, pready}, 34'd1);
  endtask

  task automatic put(port_sel_type p, logic [31:0] d);
    exp_q.push_back({d, p});
  endtask

  // one component, most significant part first
  task automatic comp(port_sel_type p, logic r24, logic [23:0] v);
    if (p == PORT_REG_READ && r24)
    begin
      put(p, 32'(v[23:8]));
      put(p, 32'({v[7:0], 8'h00}));
    end
    else if (p == PORT_REG_READ)
      put(p, 32'({v[11:0], 4'h0}));
    else if (p == PORT_BYTE_SERIAL && r24)
    begin
      put(p, 32'(v[23:16]));
      put(p, 32'(v[15:8]));
      put(p, 32'(v[7:0]));
      put(p, 32'h0000_0000);
    end
    else if (p == PORT_BYTE_SERIAL)
    begin
      put(p, 32'(v[11:4]));
      put(p, 32'({v[3:0], 4'h0}));
    end
    else
      put(p, {v, 8'h00});
  endtask

  task automatic send(logic [23:0] re, logic [23:0] im);
    int n;
    @(posedge clk);
    smp_valid <= 1'b1;
    smp <= {re, im};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (smp_ready !== 1'b1 && n < 300);
    smp_valid <= 1'b0;
    check("smp_ready", {33'b0, smp_ready}, 34'd1);
  endtask

  always @(posedge clk)
  begin
    st = rnd();
    stall <= st[0] & st[1];
  end

  always @(posedge clk)
  begin
    cyc <= rate_clr ? 0 : cyc + 1;
    if (rate_clr)
      spend <= 0;
    if (rstn && out_valid === 1'b1 && out_ready === 1'b1)
    begin
      // cost in half-bytes: the transfer width in bytes, doubled
      cost = (out_xfer.port == PORT_FIBER) ? 8 : (out_xfer.port == PORT_BYTE_SERIAL) ? 2 : 4;
      spend <= spend + cost;
      check("rate", {33'b0, spend + cost <= CAP + 3 * (cyc + 2)}, 34'd1);
      if (exp_q.size() == 0)
        check("extra", 34'd1, 34'd0);
      else
        check("xfer", out_xfer, exp_q.pop_front());
    end
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches++;
    final_report();
  end

  initial
  begin
    int c;
    int n;
    port_sel_type p;
    logic cp;
    logic r24;
    logic have_pend;
    logic [23:0] pend;
    logic [23:0] re;
    logic [23:0] im;
    logic [31:0] cfg;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0000_0000);
    check("ctrl", 34'(rd), 34'd0);
    apb(1'b0, 12'h004, 32'h0000_0000);
    check("fmt", 34'(rd[7:0]), 34'd0);
    apb(1'b0, 12'h008, 32'h0000_0000);
    check("unmapped", {err, 1'b0, rd}, {1'b1, 33'd0});
    // the last pass repeats fiber 12-bit real after an unpaired stop
    for (int k = 0; k < 13; k++)
    begin
      c = (k == 12) ? 8 : k;
      p = port_sel_type'(c / 4);
      cp = c[1];
      r24 = c[0];
      cfg = {26'h0, 2'(c / 4), 1'b0, r24, cp, 1'b0};
      apb(1'b1, 12'h000, cfg);
      rate_clr <= 1'b1;
      apb(1'b1, 12'h000, cfg | 32'h0000_0001);
      rate_clr <= 1'b0;
      apb(1'b0, 12'h004, 32'h0000_0000);
      check("start", 34'({rd[7:4], rd[0]}), 34'({p, cp, r24, 1'b1}));
      have_pend = 1'b0;
      if (k == 3)
      begin
        hold <= 1'b1;
        fork
          begin
            repeat (40) @(posedge clk);
            check("full", {32'b0, out_valid, smp_ready}, 34'd2);
            hold <= 1'b0;
          end
        join_none
      end
      for (int i = 0; i < 12; i++)
      begin
        if (i == 6)
          apb(1'b1, 12'h000, cfg ^ 32'h0000_0007); // flip format mid-run
        re = 24'({rnd(), rnd()});
        im = 24'({rnd(), rnd()});
        if (!r24)
        begin
          re[23:12] = 12'h000;
          im[23:12] = 12'h000;
        end
        if (p == PORT_FIBER && !r24 && cp)
          put(p, {re[11:0], 4'h0, im[11:0], 4'h0});
        else if (p == PORT_FIBER && !r24 && have_pend)
        begin
          put(p, {pend[11:0], 4'h0, re[11:0], 4'h0});
          have_pend = 1'b0;
        end
        else if (p == PORT_FIBER && !r24)
        begin
          pend = re;
          have_pend = 1'b1;
        end
        else
        begin
          comp(p, r24, re);
          if (cp)
            comp(p, r24, im);
        end
        // decimated stream: complex fiber samples arrive at a reduced rate
        if (p == PORT_FIBER && cp)
          repeat (2) @(posedge clk);
        send(re, im);
      end
      apb(1'b0, 12'h004, 32'h0000_0000);
      check("held", 34'(rd[7:4]), 34'({p, cp, r24}));
      n = 0;
      while (exp_q.size() > 0 && n < 3000)
      begin
        @(posedge clk);
        n++;
      end
      check("drain", 34'(exp_q.size()), 34'd0);
      if (k == 8)
        send(24'h000_abc, 24'h000_123);
      apb(1'b1, 12'h000, cfg);
      apb(1'b0, 12'h004, 32'h0000_0000);
      check("stop", 34'(rd[2:0]), 34'd0);
    end
    repeat (10) @(posedge clk);
    final_report();
  end
endmodule // sample_output_packer_test

// [tb/xfer_sink.sv]
`timescale 1ns/1ps
module xfer_sink (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic hold,
  input  wire logic stall,
  output logic      out_ready
);
  // registered ready: the neighbour answers one cycle late, never early
  always_ff @(posedge clk)
  begin
    out_ready <= rstn & ~hold & ~stall;
  end
endmodule // xfer_sink
